// *** dpt_chk.sv ***
// Port assertions for the timer unit
`timescale 1ns/1ps
`include "dpt_regs.vh"
module dpt_chk #(
    parameter [1:0] MODE = 2'h0,
    parameter LITE = 0
) (
    input wire ref_clk,
    input wire reset_n,
    input wire clk_en,
    input wire enable,
    input wire trigger,
    input wire [31:0] delay_setting,
    input wire result,
    input wire [31:0] elapsed_count,
    input wire pass_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire on = clk_en && (enable || LITE != 0);
    sequence s_quiet; !result [*3]; endsequence
    property p_off; clk_en && !enable && LITE == 0 |=> !result && elapsed_count == 0 && !pass_flag; endproperty
    a_off: assert property (p_off) else $error("outputs not cleared");
    property p_pass; clk_en && LITE == 0 |=> pass_flag == $past(enable); endproperty
    a_pass: assert property (p_pass) else $error("pass flag wrong");
    property p_lite; LITE != 0 |-> !pass_flag; endproperty
    a_lite: assert property (p_lite) else $error("lite pass flag set");
    property p_sat; $stable(delay_setting) |-> elapsed_count <= delay_setting; endproperty
    a_sat: assert property (p_sat) else $error("elapsed above setting");
    property p_rlow; MODE == `DPT_MODE_RISE && on && !trigger |=> !result; endproperty
    a_rlow: assert property (p_rlow) else $error("rise result without trigger");
    // Delay of at least two ms keeps the output low a while
    property p_rwait; MODE == `DPT_MODE_RISE && on && $rose(trigger) && delay_setting > 1 |=> s_quiet; endproperty
    a_rwait: assert property (p_rwait) else $error("rise result too early");
    property p_fall; MODE == `DPT_MODE_FALL && on && trigger |=> result; endproperty
    a_fall: assert property (p_fall) else $error("fall result low");
    // A one-ms pulse may last only two cycles when the tick is one cycle
    property p_pulse; MODE == `DPT_MODE_PULSE && on && $rose(result) && delay_setting > 1 |-> result [*4]; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse too short");
endmodule

// *** dpt_regs.vh ***
// Timing constants for the delay and pulse timer unit
`ifndef DPT_REGS_VH
`define DPT_REGS_VH
`define DPT_CLK_PERIOD_NS 10
`define DPT_TICK_NS 1000000
`define DPT_TICK_CYCLES (`DPT_TICK_NS / `DPT_CLK_PERIOD_NS)
`define DPT_PRESC_W 17
`define DPT_TIME_W 32
`define DPT_MODE_W 2
`define DPT_MODE_RISE 2'h0
`define DPT_MODE_FALL 2'h1
`define DPT_MODE_PULSE 2'h2
`define DPT_ST_IDLE 2'h0
`define DPT_ST_RUN 2'h1
`define DPT_ST_HOLD 2'h2
`endif

// *** dpt_src.sv ***
// Neighbouring block model that supplies the delay setting
`timescale 1ns/1ps
module dpt_src (
    input wire ref_clk,
    input wire [31:0] value,
    output reg [31:0] delay_setting
);
    always @(posedge ref_clk) begin
        delay_setting <= value;
    end
endmodule

// *** dpt_timer.v ***
// Delay and pulse timer: rise delay, fall delay and fixed pulse, full or lite form
// Functional notes
// (RULE_01) Rise delay: result after trigger held delay_setting
// (RULE_02) Rise delay: early trigger fall restarts full delay
// (RULE_03) Enable low forces every output to zero
// (RULE_04) Pulse: each trigger rise gives delay_setting pulse
// (RULE_05) Pulse: trigger ignored while pulse active
// (RULE_06) Delay setting is a live input, used now
// (RULE_07) Fall delay lite: always enabled, no pass
// (RULE_08) Rise delay lite: always enabled, no pass
// (RULE_09) Fixed pulse lite: always enabled, no pass
// (RULE_10) Fall delay: result held delay_setting after fall
// (RULE_11) Fall delay: trigger rise keeps result, restarts later
// (RULE_12) Elapsed count saturates, clears on restart/abandon
// (RULE_13) Pass flag follows the enable input
`timescale 1ns/1ps
`include "dpt_regs.vh"

module dpt_timer #(
    parameter [1:0] MODE = `DPT_MODE_RISE,
    parameter LITE = 0,
    parameter [31:0] TICK_CYCLES = `DPT_TICK_CYCLES
) (
    input wire ref_clk,
    input wire reset_n,
    input wire clk_en,
    input wire enable,
    input wire trigger,
    input wire [31:0] delay_setting,
    output reg result,
    output reg [31:0] elapsed_count,
    output reg pass_flag
);

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [31:0] presc_reg;
    reg [31:0] presc_next;
    reg [31:0] count_next;
    reg result_next;
    reg trig_reg;
    reg run_en;
    wire ms_tick;
    wire trig_rise;
    wire trig_fall;
    wire done;

    // Lite forms act as permanently enabled
    always @* begin
        run_en = (LITE != 0) ? 1'b1 : enable;
    end

    assign ms_tick = (presc_reg == TICK_CYCLES - 32'h00000001);
    assign trig_rise = trigger & ~trig_reg;
    assign trig_fall = ~trigger & trig_reg;
    // (RULE_06) Live setting compare
    assign done = (elapsed_count >= delay_setting);

    always @* begin
        state_next = state_reg;
        count_next = elapsed_count;
        result_next = result;
        presc_next = ms_tick ? 32'h00000000 : presc_reg + 32'h00000001;
        if (!run_en) begin
            // (RULE_03) Disable clears all
            state_next = `DPT_ST_IDLE;
            count_next = 32'h00000000;
            result_next = 1'b0;
            presc_next = 32'h00000000;
        end else begin
            case (MODE)
                `DPT_MODE_RISE: begin
                    // (RULE_08) Lite shares this path
                    if (!trigger) begin
                        // (RULE_02) Abandon on early fall
                        state_next = `DPT_ST_IDLE;
                        count_next = 32'h00000000;
                        result_next = 1'b0;
                        presc_next = 32'h00000000;
                    end else if (state_reg == `DPT_ST_IDLE) begin
                        state_next = `DPT_ST_RUN;
                        presc_next = 32'h00000000;
                    end else if (state_reg == `DPT_ST_RUN) begin
                        // (RULE_01) Raise when delay elapsed
                        if (done) begin
                            state_next = `DPT_ST_HOLD;
                            result_next = 1'b1;
                        end else if (ms_tick) begin
                            count_next = elapsed_count + 32'h00000001;
                        end
                    end
                end
                `DPT_MODE_FALL: begin
                    // (RULE_07) Lite shares this path
                    if (trigger) begin
                        // (RULE_11) Rise keeps result, clears count
                        state_next = `DPT_ST_HOLD;
                        result_next = 1'b1;
                        count_next = 32'h00000000;
                        presc_next = 32'h00000000;
                    end else if (state_reg == `DPT_ST_HOLD) begin
                        state_next = `DPT_ST_RUN;
                        presc_next = 32'h00000000;
                    end else if (state_reg == `DPT_ST_RUN) begin
                        // (RULE_10) Drop after delay
                        if (done) begin
                            state_next = `DPT_ST_IDLE;
                            result_next = 1'b0;
                        end else if (ms_tick) begin
                            count_next = elapsed_count + 32'h00000001;
                        end
                    end
                end
                `DPT_MODE_PULSE: begin
                    // (RULE_09) Lite shares this path
                    if (state_reg == `DPT_ST_RUN) begin
                        // (RULE_05) Trigger ignored while running
                        if (done) begin
                            state_next = `DPT_ST_IDLE;
                            result_next = 1'b0;
                        end else if (ms_tick) begin
                            count_next = elapsed_count + 32'h00000001;
                        end
                    end else if (trig_rise) begin
                        // (RULE_04) Start fixed pulse
                        state_next = `DPT_ST_RUN;
                        result_next = (delay_setting != 32'h00000000);
                        count_next = 32'h00000000;
                        presc_next = 32'h00000000;
                    end
                end
                default: begin
                    state_next = `DPT_ST_IDLE;
                    result_next = 1'b0;
                end
            endcase
        end
        // (RULE_12) Saturate at setting
        if (count_next > delay_setting) begin
            count_next = delay_setting;
        end
    end

    // Edge history tracks trigger even when disabled, so enable rising
    // over a high trigger does not fake a pulse edge.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= `DPT_ST_IDLE;
            presc_reg <= 32'h00000000;
            elapsed_count <= 32'h00000000;
            result <= 1'b0;
            trig_reg <= 1'b0;
            pass_flag <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            presc_reg <= presc_next;
            elapsed_count <= count_next;
            result <= result_next;
            trig_reg <= trigger;
            // (RULE_13) Pass follows enable
            pass_flag <= (LITE != 0) ? 1'b0 : enable;
        end
    end

endmodule

// *** testbench.sv ***
// Self-checking bench for the timer unit
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench;
    reg ref_clk = 0, reset_n = 0, enable = 0, trigger = 0, clk_en = 1;
    reg [31:0] value = 32'h3;
    wire [31:0] delay_setting, e0, e1, e2;
    wire [2:0] q, p;
    int fails = 0, check_count = 0;
    dpt_src i_dpt_src(.ref_clk(ref_clk), .value(value), .delay_setting(delay_setting));
    dpt_timer #(.TICK_CYCLES(32'h2)) i_dpt_timer_r(.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .enable(enable), .trigger(trigger), .delay_setting(delay_setting), .result(q[0]), .elapsed_count(e0), .pass_flag(p[0]));
    dpt_timer #(.MODE(2'h1), .TICK_CYCLES(32'h2)) i_dpt_timer_f(.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .enable(enable), .trigger(trigger), .delay_setting(delay_setting), .result(q[1]), .elapsed_count(e1), .pass_flag(p[1]));
    dpt_timer #(.MODE(2'h2), .LITE(1), .TICK_CYCLES(32'h2)) i_dpt_timer_p(.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .enable(enable), .trigger(trigger), .delay_setting(delay_setting), .result(q[2]), .elapsed_count(e2), .pass_flag(p[2]));
    initial forever #5 ref_clk = ~ref_clk;
    task w(input int n); repeat (n) @(posedge ref_clk); endtask
    task close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task t_start;
        enable <= 1; w(2); trigger <= 1; w(4); #1;
        `CHK({q, p[1:0]}, 5'h1B)
        w(8); #1;
        `CHK({q, e0}, {3'h3, 32'h3})
    endtask
    task t_retrig;
        w(1); trigger <= 0; w(2); #1;
        `CHK({q[1:0], e0}, {2'h2, 32'h0})
        trigger <= 1; w(3); trigger <= 0; w(3); trigger <= 1; w(5); #1;
        `CHK(q, 3'h2)
        trigger <= 0; w(14); #1;
        `CHK({q[1], e1, e2}, {1'h0, 32'h3, 32'h3})
    endtask
    task t_live;
        value <= 32'h5; w(2); trigger <= 1; w(20); #1;
        `CHK({q[0], e0}, {1'h1, 32'h5})
    endtask
    // Clock enable low freezes all state; trigger fall is seen only after it returns
    task t_freeze;
        clk_en <= 0; trigger <= 0; w(4); #1;
        `CHK({q[1:0], e0}, {2'h3, 32'h5})
        clk_en <= 1; w(2); #1;
        `CHK({q[0], e0}, {1'h0, 32'h0})
    endtask
    task t_off;
        enable <= 0; w(2); #1;
        `CHK({q[1:0], p, e0, e1}, {5'h0, 64'h0})
        `CHK(e2, 32'h5)
    endtask
    initial begin
        w(6); reset_n <= 1; w(1);
        t_start; t_retrig; t_live; t_freeze; t_off;
        close_out;
    end
    initial begin
        #50us; fails++; close_out;
    end
endmodule
bind dpt_timer dpt_chk #(.MODE(MODE), .LITE(LITE)) i_dpt_chk(.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .enable(enable), .trigger(trigger), .delay_setting(delay_setting), .result(result), .elapsed_count(elapsed_count),
    .pass_flag(pass_flag));
